// File: design/uim_pkg.sv
// Constants, field layout and state types of the universal input measurement block
package uim_pkg;
    // ==========================================================
    // Channels and timing base
    localparam int NCH = 7;
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 10;
    localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
    localparam int MS_US = 1000;
    localparam int MS_TICKS = MS_US / TICK_US;
    // ==========================================================
    // Analog update periods and settling times (us), in ticks
    localparam int UPD_DIS_US = 1670;
    localparam int UPD_5060_US = 3330;
    localparam int UPD_BOTH_US = 16670;
    localparam int UPD_DIS_TK = UPD_DIS_US / TICK_US;
    localparam int UPD_5060_TK = UPD_5060_US / TICK_US;
    localparam int UPD_BOTH_TK = UPD_BOTH_US / TICK_US;
    localparam int SET_DIS_US = 10000;
    localparam int SET_50_US = 76700;
    localparam int SET_60_US = 63300;
    localparam int SET_BOTH_US = 396700;
    localparam int SET_DIS_TK = SET_DIS_US / TICK_US;
    localparam int SET_50_TK = SET_50_US / TICK_US;
    localparam int SET_60_TK = SET_60_US / TICK_US;
    localparam int SET_BOTH_TK = SET_BOTH_US / TICK_US;
    localparam int SW_US = 30000;
    localparam int SW_TK = SW_US / TICK_US;
    // ==========================================================
    // Frequency and PWM counting
    localparam int FCNT_DIV = 2000;
    localparam int FCNT_HZ = CLK_MHZ * 1000000 / FCNT_DIV;
    localparam int FMAX_HZ = 10000;
    localparam logic [15:0] FMIN_PER = 16'(FCNT_HZ / FMAX_HZ);
    localparam int FDEB1_NS = 142;
    localparam int FDEB2_NS = 1140;
    localparam int FDEB3_NS = 6100;
    localparam int FDEB1_CY = (FDEB1_NS * CLK_MHZ + 999) / 1000;
    localparam int FDEB2_CY = (FDEB2_NS * CLK_MHZ + 999) / 1000;
    localparam int FDEB3_CY = (FDEB3_NS * CLK_MHZ + 999) / 1000;
    localparam logic [9:0] RECOV_MS = 10'h064;
    // ==========================================================
    // Thresholds
    localparam logic [15:0] CUR_OPEN_UA = 16'h0bb8;
    localparam logic [15:0] RANGE_HI = 16'hf000;
    localparam logic [15:0] RANGE_LO = 16'h0c00;
    // ==========================================================
    // Register offsets and fields
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] DEB_OFS = 8'h1c;
    localparam logic [7:0] RES_OFS = 8'h20;
    localparam logic [7:0] STAT_OFS = 8'h3c;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_CUR_BIT = 3;
    localparam int CFG_FILT_LSB = 4;
    localparam int CFG_POL_BIT = 6;
    localparam int CFG_FDEB_LSB = 7;
    localparam int CFG_AVG_LSB = 9;
    localparam int CFG_AUTO_BIT = 11;
    localparam int CFG_RNG_LSB = 12;
    localparam logic [15:0] CFG_RST = 16'h0001;
    localparam logic [9:0] DEB_RST = 10'h032;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_VOLT = 3'h1;
    localparam logic [2:0] MODE_CUR = 3'h2;
    localparam logic [2:0] MODE_DISC = 3'h3;
    localparam logic [2:0] MODE_RES = 3'h4;
    localparam logic [2:0] MODE_FREQ = 3'h5;
    localparam logic [2:0] MODE_PWM = 3'h6;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        RS_IDLE = 3'b001,
        RS_HOLD = 3'b010,
        RS_MEAS = 3'b100
    } uim_rs_e;

    typedef struct packed {
        logic [NCH-1:0][15:0] cfg;
        logic [9:0] deb;
        logic [31:0] rdata;
        logic [NCH-1:0] s1;
        logic [NCH-1:0] s2;
        logic [15:0] tcnt;
        logic [7:0] mcnt;
        logic [10:0] fcnt;
        logic [NCH-1:0][15:0] ucnt;
        logic [NCH-1:0][15:0] samp;
        logic [NCH-1:0][31:0] result;
        logic [NCH-1:0] dstate;
        logic [NCH-1:0][9:0] dcnt;
        logic [NCH-1:0][9:0] gcnt;
        logic [NCH-1:0] filt;
        logic [NCH-1:0] fprev;
        logic [NCH-1:0][15:0] pcnt;
        logic [NCH-1:0][15:0] hcnt;
        logic [NCH-1:0] sat;
        logic [NCH-1:0] recov;
        logic [NCH-1:0][9:0] rcnt;
        logic [NCH-1:0][1:0] range;
        uim_rs_e rs;
        logic [2:0] rch;
        logic [15:0] hold;
        logic isrc;
        logic [1:0] rng_out;
    } uim_state_s;
    // ==========================================================
    // Lookups
    function automatic logic [15:0] upd_ticks(input logic [1:0] f);
        case (f)
            2'h0: upd_ticks = 16'(UPD_DIS_TK);
            2'h3: upd_ticks = 16'(UPD_BOTH_TK);
            default: upd_ticks = 16'(UPD_5060_TK);
        endcase
    endfunction

    function automatic logic [15:0] hold_ticks(input logic [1:0] f);
        case (f)
            2'h1: hold_ticks = 16'(SW_TK + SET_50_TK);
            2'h2: hold_ticks = 16'(SW_TK + SET_60_TK);
            2'h3: hold_ticks = 16'(SW_TK + SET_BOTH_TK);
            default: hold_ticks = 16'(SW_TK + SET_DIS_TK);
        endcase
    endfunction

    function automatic logic [9:0] fdeb_cycles(input logic [1:0] s);
        case (s)
            2'h1: fdeb_cycles = 10'(FDEB1_CY);
            2'h2: fdeb_cycles = 10'(FDEB2_CY);
            default: fdeb_cycles = 10'(FDEB3_CY);
        endcase
    endfunction

    function automatic logic [15:0] ema(input logic [15:0] a, input logic [15:0] n,
                                        input logic [1:0] k);
        logic signed [17:0] df;
        df = $signed({2'b00, n}) - $signed({2'b00, a});
        case (k)
            2'h1: ema = a + 16'(df >>> 1);
            2'h2: ema = a + 16'(df >>> 2);
            2'h3: ema = a + 16'(df >>> 3);
            default: ema = n;
        endcase
    endfunction
endpackage

// File: design/uim_top.sv
// Universal input measurement: analog, discrete, resistance and frequency/PWM channels
//
// Function
// - 4-20 mA range, under 3 mA reads zero
// - Discrete level sampled every millisecond
// - Zero debounce time passes samples straight through
// - Result update period follows filter setting
// - Result settles within filter settling time
// - Disabled filter still settles within 10 ms
// - Auto range switches ranges; fixed range stops it
// - Range change holds result 30 ms plus settling
// - One current source shared round robin
// - Frequency and duty counted with fast clock
// - Seven dedicated 16-bit counters, 1 Hz-10 kHz
// - Polarity selects the active input edge
// - Optional spike filter on frequency input
// - Optional averaging of successive readings
// - Overfrequency enters recovery, reports 0 percent
// - No edges gives 0/100 percent on saturation
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module uim_top #(
    parameter int TICK_CYCLES = uim_pkg::TICK_CYCLES_DEF
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [31:0] RD_DATA,
    input wire logic [6:0] UIN_PIN,
    input wire logic ADC_VALID,
    input wire logic [2:0] ADC_CHAN,
    input wire logic [15:0] ADC_DATA,
    output logic ISRC_EN,
    output logic [2:0] ISRC_SEL,
    output logic [1:0] RES_RANGE,
    output logic [6:0] DISC_OUT
);
    uim_pkg::uim_state_s q;
    uim_pkg::uim_state_s d;

    // ==========================================================
    // Next state
    always_comb begin
        int j;
        logic tick;
        logic mst;
        logic ft;
        logic upd;
        logic raw;
        logic edg;
        logic lvl;
        logic res_upd;
        logic found;
        logic [2:0] nxt;
        logic [3:0] nres;
        logic [2:0] mode;
        logic [1:0] fs;
        logic [1:0] fd;
        logic [1:0] av;
        logic pol;
        logic [5:0] idx;
        logic [7:0] roff;
        logic [15:0] rc;
        logic [1:0] rcf;
        j = 0;
        tick = 1'b0;
        mst = 1'b0;
        ft = 1'b0;
        upd = 1'b0;
        raw = 1'b0;
        edg = 1'b0;
        lvl = 1'b0;
        res_upd = 1'b0;
        found = 1'b0;
        nxt = '0;
        nres = '0;
        mode = '0;
        fs = '0;
        fd = '0;
        av = '0;
        pol = 1'b0;
        idx = ADDR[7:2];
        roff = ADDR - uim_pkg::RES_OFS;
        rc = '0;
        rcf = '0;
        d = q;

        // ======================================================
        // Synchronisers and time bases
        d.s1 = UIN_PIN;
        d.s2 = q.s1;
        tick = (q.tcnt == 16'(TICK_CYCLES - 1));
        d.tcnt = tick ? 16'h0000 : q.tcnt + 16'h0001;
        if (tick) begin
            mst = (q.mcnt == 8'(uim_pkg::MS_TICKS - 1));
            d.mcnt = mst ? 8'h00 : q.mcnt + 8'h01;
        end
        ft = (q.fcnt == 11'(uim_pkg::FCNT_DIV - 1));
        d.fcnt = ft ? 11'h000 : q.fcnt + 11'h001;

        // ======================================================
        // Register writes and reads
        if (WR_EN && ADDR[1:0] == 2'h0) begin
            if (ADDR < uim_pkg::DEB_OFS) begin
                d.cfg[idx[2:0]] = WR_DATA[15:0];
            end else if (ADDR == uim_pkg::DEB_OFS) begin
                d.deb = WR_DATA[9:0];
            end
        end
        d.rdata = '0;
        if (RD_EN && ADDR[1:0] == 2'h0) begin
            if (ADDR < uim_pkg::DEB_OFS) begin
                d.rdata = {16'h0000, q.cfg[idx[2:0]]};
            end else if (ADDR == uim_pkg::DEB_OFS) begin
                d.rdata = {22'h000000, q.deb};
            end else if (ADDR < uim_pkg::STAT_OFS) begin
                d.rdata = q.result[roff[4:2]];
            end else if (ADDR == uim_pkg::STAT_OFS) begin
                d.rdata = {2'h0, q.rng_out, q.rs, q.rch, q.isrc, q.recov, 7'h00, q.dstate};
            end
        end

        // ======================================================
        // ADC sample capture
        if (ADC_VALID && ADC_CHAN < 3'(uim_pkg::NCH)) begin
            d.samp[ADC_CHAN] = ADC_DATA;
        end

        // ======================================================
        // Per channel measurement
        for (int c = 0; c < uim_pkg::NCH; c++) begin
            mode = q.cfg[c][uim_pkg::CFG_MODE_LSB +: 3];
            fs = q.cfg[c][uim_pkg::CFG_FILT_LSB +: 2];
            fd = q.cfg[c][uim_pkg::CFG_FDEB_LSB +: 2];
            av = q.cfg[c][uim_pkg::CFG_AVG_LSB +: 2];
            pol = q.cfg[c][uim_pkg::CFG_POL_BIT];
            if (mode == uim_pkg::MODE_RES) begin
                nres = nres + 4'h1;
            end
            upd = 1'b0;
            if (tick) begin
                if (q.ucnt[c] >= uim_pkg::upd_ticks(fs) - 16'h0001) begin
                    d.ucnt[c] = 16'h0000;
                    upd = 1'b1;
                end else begin
                    d.ucnt[c] = q.ucnt[c] + 16'h0001;
                end
            end
            if (mode != uim_pkg::MODE_FREQ && mode != uim_pkg::MODE_PWM) begin
                d.filt[c] = q.s2[c];
                d.fprev[c] = q.s2[c];
                d.pcnt[c] = '0;
                d.hcnt[c] = '0;
            end
            case (mode)
                uim_pkg::MODE_VOLT: begin
                    if (upd) begin
                        d.result[c] = {16'h0000, q.samp[c]};
                    end
                end
                uim_pkg::MODE_CUR: begin
                    if (upd) begin
                        if (q.cfg[c][uim_pkg::CFG_CUR_BIT] && q.samp[c] < uim_pkg::CUR_OPEN_UA) begin
                            d.result[c] = '0;
                        end else begin
                            d.result[c] = {16'h0000, q.samp[c]};
                        end
                    end
                end
                uim_pkg::MODE_DISC: begin
                    if (mst) begin
                        lvl = q.s2[c] ^ pol;
                        if (q.deb == 10'h000) begin
                            d.dstate[c] = lvl;
                            d.dcnt[c] = '0;
                        end else if (lvl == q.dstate[c]) begin
                            d.dcnt[c] = '0;
                        end else if (q.dcnt[c] >= q.deb - 10'h001) begin
                            d.dstate[c] = lvl;
                            d.dcnt[c] = '0;
                        end else begin
                            d.dcnt[c] = q.dcnt[c] + 10'h001;
                        end
                    end
                    d.result[c] = {31'h00000000, d.dstate[c]};
                end
                uim_pkg::MODE_RES: begin
                    if (upd && q.rs == uim_pkg::RS_MEAS && q.rch == 3'(c)) begin
                        res_upd = 1'b1;
                        d.result[c] = {14'h0000, q.range[c], q.samp[c]};
                    end
                end
                uim_pkg::MODE_FREQ, uim_pkg::MODE_PWM: begin
                    raw = q.s2[c];
                    if (fd == 2'h0) begin
                        d.filt[c] = raw;
                    end else if (raw != q.filt[c]) begin
                        if (q.gcnt[c] >= uim_pkg::fdeb_cycles(fd) - 10'h001) begin
                            d.filt[c] = raw;
                            d.gcnt[c] = '0;
                        end else begin
                            d.gcnt[c] = q.gcnt[c] + 10'h001;
                        end
                    end else begin
                        d.gcnt[c] = '0;
                    end
                    d.fprev[c] = q.filt[c];
                    lvl = q.filt[c] ^ pol;
                    edg = lvl & ~(q.fprev[c] ^ pol);
                    if (ft) begin
                        if (q.pcnt[c] == 16'hffff) begin
                            d.pcnt[c] = '0;
                            d.hcnt[c] = '0;
                            d.sat[c] = 1'b1;
                            if (!q.recov[c]) begin
                                d.result[c] = {16'hffff, lvl ? 16'hffff : 16'h0000};
                            end
                        end else begin
                            d.pcnt[c] = q.pcnt[c] + 16'h0001;
                            d.hcnt[c] = q.hcnt[c] + {15'h0000, lvl};
                        end
                    end
                    if (mst && q.recov[c]) begin
                        if (q.rcnt[c] >= uim_pkg::RECOV_MS - 10'h001) begin
                            d.recov[c] = 1'b0;
                            d.rcnt[c] = '0;
                            d.sat[c] = 1'b1;
                        end else begin
                            d.rcnt[c] = q.rcnt[c] + 10'h001;
                        end
                    end
                    if (edg) begin
                        d.pcnt[c] = {15'h0000, ft};
                        d.hcnt[c] = {15'h0000, ft};
                        d.sat[c] = 1'b0;
                        if (q.pcnt[c] < uim_pkg::FMIN_PER && !q.recov[c]) begin
                            d.recov[c] = 1'b1;
                            d.rcnt[c] = '0;
                            d.result[c] = '0;
                        end else if (!q.recov[c] && q.sat[c]) begin
                            d.result[c] = {q.pcnt[c], q.hcnt[c]};
                        end else if (!q.recov[c]) begin
                            d.result[c] = {uim_pkg::ema(q.result[c][31:16], q.pcnt[c], av),
                                           uim_pkg::ema(q.result[c][15:0], q.hcnt[c], av)};
                        end
                    end
                end
                default: begin
                    d.result[c] = '0;
                end
            endcase
        end

        // ======================================================
        // Shared current source scheduler
        for (int i = 1; i <= uim_pkg::NCH; i++) begin
            j = int'(q.rch) + i;
            if (j >= uim_pkg::NCH) begin
                j = j - uim_pkg::NCH;
            end
            if (!found && q.cfg[j][uim_pkg::CFG_MODE_LSB +: 3] == uim_pkg::MODE_RES) begin
                found = 1'b1;
                nxt = 3'(j);
            end
        end
        rcf = q.cfg[q.rch][uim_pkg::CFG_RNG_LSB +: 2];
        rc = q.samp[q.rch];
        case (q.rs)
            uim_pkg::RS_IDLE: begin
                d.isrc = 1'b0;
                if (found) begin
                    d.rch = nxt;
                    d.isrc = 1'b1;
                    d.hold = uim_pkg::hold_ticks(q.cfg[nxt][uim_pkg::CFG_FILT_LSB +: 2]);
                    if (!q.cfg[nxt][uim_pkg::CFG_AUTO_BIT]) begin
                        d.range[nxt] = q.cfg[nxt][uim_pkg::CFG_RNG_LSB +: 2];
                    end
                    d.rs = uim_pkg::RS_HOLD;
                end
            end
            uim_pkg::RS_HOLD: begin
                if (q.cfg[q.rch][uim_pkg::CFG_MODE_LSB +: 3] != uim_pkg::MODE_RES) begin
                    d.rs = uim_pkg::RS_IDLE;
                end else if (tick) begin
                    if (q.hold == 16'h0000) begin
                        d.rs = uim_pkg::RS_MEAS;
                    end else begin
                        d.hold = q.hold - 16'h0001;
                    end
                end
            end
            uim_pkg::RS_MEAS: begin
                if (q.cfg[q.rch][uim_pkg::CFG_MODE_LSB +: 3] != uim_pkg::MODE_RES) begin
                    d.rs = uim_pkg::RS_IDLE;
                end else if (!q.cfg[q.rch][uim_pkg::CFG_AUTO_BIT]) begin
                    if (rcf != q.range[q.rch]) begin
                        d.range[q.rch] = rcf;
                        d.hold = uim_pkg::hold_ticks(q.cfg[q.rch][uim_pkg::CFG_FILT_LSB +: 2]);
                        d.rs = uim_pkg::RS_HOLD;
                    end else if (res_upd && nres > 4'h1) begin
                        d.rs = uim_pkg::RS_IDLE;
                    end
                end else if (res_upd) begin
                    if (rc > uim_pkg::RANGE_HI && q.range[q.rch] != 2'h3) begin
                        d.range[q.rch] = q.range[q.rch] + 2'h1;
                        d.hold = uim_pkg::hold_ticks(q.cfg[q.rch][uim_pkg::CFG_FILT_LSB +: 2]);
                        d.rs = uim_pkg::RS_HOLD;
                    end else if (rc < uim_pkg::RANGE_LO && q.range[q.rch] != 2'h0) begin
                        d.range[q.rch] = q.range[q.rch] - 2'h1;
                        d.hold = uim_pkg::hold_ticks(q.cfg[q.rch][uim_pkg::CFG_FILT_LSB +: 2]);
                        d.rs = uim_pkg::RS_HOLD;
                    end else if (nres > 4'h1) begin
                        d.rs = uim_pkg::RS_IDLE;
                    end
                end
            end
            default: begin
                d.rs = uim_pkg::RS_IDLE;
            end
        endcase
        d.rng_out = d.range[d.rch];
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            q <= '0;
            q.cfg <= {uim_pkg::NCH{uim_pkg::CFG_RST}};
            q.deb <= uim_pkg::DEB_RST;
            q.rs <= uim_pkg::RS_IDLE;
        end else if (CE) begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign RD_DATA = q.rdata;
    assign ISRC_EN = q.isrc;
    assign ISRC_SEL = q.rch;
    assign RES_RANGE = q.rng_out;
    assign DISC_OUT = q.dstate;
endmodule

// File: verif/testbench.sv
// Register-level tests of the universal input measurement block
`timescale 1ns/1ps
module testbench;
    logic CLK, SYS_RST, CE, WR_EN, RD_EN, ADC_VALID, ISRC_EN;
    logic [7:0] ADDR;
    logic [31:0] WR_DATA, RD_DATA, d;
    logic [6:0] UIN_PIN, DISC_OUT, lvl;
    logic [2:0] ADC_CHAN, ISRC_SEL;
    logic [15:0] ADC_DATA, half, adc;
    logic [1:0] RES_RANGE;
    int n_errors = 0;
    int cmp_count = 0;
    uim_top #(.TICK_CYCLES(2)) u_uim_top (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
        .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
        .UIN_PIN(UIN_PIN), .ADC_VALID(ADC_VALID), .ADC_CHAN(ADC_CHAN), .ADC_DATA(ADC_DATA),
        .ISRC_EN(ISRC_EN), .ISRC_SEL(ISRC_SEL), .RES_RANGE(RES_RANGE), .DISC_OUT(DISC_OUT));
    uim_src u_uim_src (.clk(CLK), .lvl(lvl), .half(half), .adc(adc), .pin(UIN_PIN),
        .vld(ADC_VALID), .chan(ADC_CHAN), .data(ADC_DATA));
    always #4 CLK = ~CLK;
    // ==========================================================
    // Bus access and comparison
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WR_DATA <= v;
        WR_EN <= 1'b1;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1 d = RD_DATA;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), d, e);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #720000;
        n_errors++;
        give_verdict;
    end
    // ==========================================================
    // Tests
    initial begin
        CLK = 0; SYS_RST = 1; CE = 1; ADDR = 0; WR_DATA = 0; WR_EN = 0; RD_EN = 0;
        lvl = 0; half = 0; adc = 0;
        w(16);
        SYS_RST <= 1'b0;
        chk("source", {ISRC_EN, ISRC_SEL, RES_RANGE, DISC_OUT}, 32'h0);
        rdchk(8'h00, 32'h1);
        rdchk(8'h1c, 32'h32);
        rdchk(8'h3c, 32'h0200_0000);
        rdchk(8'h02, 32'h0);
        rdchk(8'h40, 32'h0);
        wr(8'h20, 32'h1234);
        rdchk(8'h20, 32'h0);
        $display("test reset done");
        adc <= 16'h0bb7;
        wr(8'h04, 32'h0002);
        w(400);
        rdchk(8'h24, 32'h0bb7);
        wr(8'h04, 32'h000a);
        w(400);
        rdchk(8'h24, 32'h0);
        adc <= 16'h0bb8;
        w(400);
        rdchk(8'h24, 32'h0bb8);
        $display("test current done");
        wr(8'h00, 32'h3);
        wr(8'h1c, 32'h0);
        lvl <= 7'h01;
        w(250);
        chk("disc", DISC_OUT[0], 1);
        rdchk(8'h20, 32'h1);
        wr(8'h1c, 32'h2);
        lvl <= 7'h00;
        w(150);
        chk("disc", DISC_OUT[0], 1);
        CE <= 1'b0;
        w(500);
        chk("frozen", DISC_OUT[0], 1);
        CE <= 1'b1;
        w(500);
        chk("disc", DISC_OUT[0], 0);
        $display("test discrete done");
        adc <= 16'hf800;
        wr(8'h08, 32'h0);
        wr(8'h08, 32'h2004);
        w(4000);
        rdchk(8'h28, 32'h0);
        w(5000);
        chk("source", {ISRC_EN, ISRC_SEL, RES_RANGE}, 32'h2a);
        rdchk(8'h28, 32'h0002_f800);
        wr(8'h08, 32'h0804);
        w(9000);
        chk("auto", RES_RANGE, 32'h3);
        rdchk(8'h28, 32'h0003_f800);
        wr(8'h08, 32'h0);
        $display("test resistance done");
        wr(8'h18, 32'h00c5);
        half <= 16'd8000;
        w(45000);
        rdchk(8'h38, 32'h0008_0004);
        half <= 16'd1000;
        w(12000);
        rdchk(8'h38, 32'h0);
        rd(8'h3c);
        chk("recovery", d[20], 1);
        $display("test frequency done");
        give_verdict;
    end
endmodule

// File: verif/uim_src.sv
// Signal source model for the universal input pins and converter samples
`timescale 1ns/1ps
module uim_src (
    input wire logic clk,
    input wire logic [6:0] lvl,
    input wire logic [15:0] half,
    input wire logic [15:0] adc,
    output logic [6:0] pin,
    output logic vld,
    output logic [2:0] chan,
    output logic [15:0] data
);
    logic [15:0] cnt;
    logic sq;
    initial begin
        cnt = 16'h0000;
        sq = 1'b0;
        vld = 1'b0;
        chan = 3'h0;
        data = 16'h0000;
    end
    // ==========================================================
    // Pins are driven push-pull, never left floating
    assign pin = {lvl[6] ^ sq, lvl[5:0]};
    // ==========================================================
    // Square wave on channel 6, far slower than any spike filter
    always @(posedge clk) begin
        cnt <= (cnt + 16'h0001 >= half) ? 16'h0000 : cnt + 16'h0001;
        if (half != 16'h0000 && cnt + 16'h0001 >= half) begin
            sq <= ~sq;
        end
        // Samples every other cycle, round robin, garbage in between
        vld <= ~vld;
        data <= vld ? ~adc : adc;
        if (vld) begin
            chan <= (chan == 3'h6) ? 3'h0 : chan + 3'h1;
        end
    end
endmodule

// File: verif/uim_top_assertions.sv
// Concurrent checks on the universal input measurement ports
`timescale 1ns/1ps
module uim_top_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] ADDR,
    input wire logic RD_EN,
    input wire logic [31:0] RD_DATA,
    input wire logic [6:0] UIN_PIN,
    input wire logic ISRC_EN,
    input wire logic [2:0] ISRC_SEL,
    input wire logic [1:0] RES_RANGE,
    input wire logic [6:0] DISC_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_still(sig);
        $stable(sig) [*8];
    endsequence
    sequence s_live;
        !$past(SYS_RST);
    endsequence
    rd_idle_a: assert property (!$past(RD_EN) |-> RD_DATA == 32'h0)
        else $error("read data outside its slot");
    rd_odd_a: assert property (RD_EN && ADDR[1:0] != 2'h0 |=> RD_DATA == 32'h0)
        else $error("unaligned read not zero");
    rd_unmap_a: assert property (RD_EN && ADDR > 8'h3c |=> RD_DATA == 32'h0)
        else $error("unmapped read not zero");
    disc_hold_a: assert property (s_live and $changed(DISC_OUT) |=> s_still(DISC_OUT))
        else $error("discrete state moved twice within a sample");
    disc_cause_a: assert property (s_live and $rose(DISC_OUT[0]) |-> $past(UIN_PIN[0], 8))
        else $error("discrete state rose without a held input");
    sel_ok_a: assert property (ISRC_EN |-> ISRC_SEL <= 3'h6)
        else $error("current source on a missing channel");
    sel_hold_a: assert property (s_live and $changed(ISRC_SEL) |=> s_still(ISRC_SEL))
        else $error("current source moved without a hold");
    range_hold_a: assert property (s_live and $changed(RES_RANGE) |=> s_still(RES_RANGE))
        else $error("range moved without a hold");
endmodule
bind uim_top uim_top_checker u_uim_top_checker (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .RD_EN(RD_EN), .RD_DATA(RD_DATA), .UIN_PIN(UIN_PIN), .ISRC_EN(ISRC_EN),
    .ISRC_SEL(ISRC_SEL), .RES_RANGE(RES_RANGE), .DISC_OUT(DISC_OUT));
